/* File: pmt_consts.svh */
// Register offsets, field positions, reset values and timing counts of the period match timer.
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

`define PMT_OFF_COUNT 12'h000
`define PMT_OFF_PERIOD 12'h004
`define PMT_OFF_CONTROL 12'h008
`define PMT_OFF_FLAGS 12'h00c
`define PMT_OFF_ENABLE 12'h010
`define PMT_OFF_FLAG_CLR 12'h014

`define PMT_CTL_CKPS_LSB 0
`define PMT_CTL_RUN_BIT 2
`define PMT_CTL_OUTPS_LSB 3
`define PMT_MATCH_FLAG_BIT 1

`define PMT_COUNT_RST 8'h00
`define PMT_PERIOD_RST 8'hff
`define PMT_CONTROL_RST 7'h00

`define PMT_DIV1_LAST 4'h0
`define PMT_DIV4_LAST 4'h3
`define PMT_DIV16_LAST 4'hf

`endif

/* File: pmt_pkg.sv */
// Types shared by the period match timer files.
package pmt_pkg;

   typedef struct packed {
      logic [3:0] output_postscale_select;
      logic timer_run;
      logic [1:0] clock_prescale_select;
   } pmt_ctl_t;

   typedef struct packed {
      logic match_pulse;
      logic time_base;
      logic shift_clock;
   } pmt_out_t;

   typedef enum logic [1:0] {
      PMT_DIV1,
      PMT_DIV4,
      PMT_DIV16
   } pmt_div_t;

endpackage : pmt_pkg

/* File: pmt_postscaler.sv */
// Postscale counter that raises an event on the match that follows the selected number of matches.
`timescale 1ns/1ns
`include "pmt_consts.svh"

module pmt_postscaler
   import pmt_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic match,
   input wire logic [WIDTH-1:0] select,
   output logic event_out
);

   logic [WIDTH-1:0] post_q;
   logic [WIDTH-1:0] post_d;

   assign event_out = match && (post_q == select) && !clear;

   always_comb begin
      post_d = post_q;
      if (clear) begin
         post_d = '0;
      end else if (match) begin
         post_d = (post_q == select) ? '0 : post_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         post_q <= '0;
      end else begin
         post_q <= post_d;
      end
   end

endmodule : pmt_postscaler

/* File: pmt_prescaler.sv */
// Prescale divider that turns every first, fourth or sixteenth instruction clock cycle into a timer tick.
`timescale 1ns/1ns
`include "pmt_consts.svh"

module pmt_prescaler
   import pmt_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic clear,
   input wire logic [1:0] select,
   output logic tick
);

   // **************************************************
   // Divide selection
   // **************************************************
   function automatic logic [WIDTH-1:0] last_count(input logic [1:0] sel);
      case (sel)
         2'h0: last_count = WIDTH'(`PMT_DIV1_LAST);
         2'h1: last_count = WIDTH'(`PMT_DIV4_LAST);
         default: last_count = WIDTH'(`PMT_DIV16_LAST);
      endcase
   endfunction : last_count

   logic [WIDTH-1:0] pre_q;
   logic [WIDTH-1:0] pre_d;
   logic at_last;

   assign at_last = (pre_q >= last_count(select));
   assign tick = run && at_last && !clear;

   always_comb begin
      pre_d = pre_q;
      if (clear) begin
         pre_d = '0;
      end else if (run) begin
         pre_d = at_last ? '0 : pre_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_d;
      end
   end

endmodule : pmt_prescaler

/* File: pmt_timer.sv */
// Top of the period match timer: bus slave, count, period compare and interrupt.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`include "pmt_consts.svh"

module pmt_timer
   import pmt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic irq,
   output logic pwm_time_base,
   output logic spi_shift_clock
);

   // **************************************************
   // Bus address phase capture
   // **************************************************
   logic wr_pend_q;
   logic wr_pend_d;
   logic [11:0] wr_addr_q;
   logic [11:0] wr_addr_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic addr_phase;

   assign addr_phase = hsel && hready && htrans[1];

   // Writes land in the data phase, so a write is always answered in one wait-free cycle.
   always_comb begin
      wr_pend_d = addr_phase && hwrite;
      wr_addr_d = addr_phase ? haddr : wr_addr_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
      end
   end

   logic wr_count;
   logic wr_period;
   logic wr_control;
   logic wr_enable;
   logic wr_flag_clr;

   assign wr_count = wr_pend_q && (wr_addr_q == `PMT_OFF_COUNT);
   assign wr_period = wr_pend_q && (wr_addr_q == `PMT_OFF_PERIOD);
   assign wr_control = wr_pend_q && (wr_addr_q == `PMT_OFF_CONTROL);
   assign wr_enable = wr_pend_q && (wr_addr_q == `PMT_OFF_ENABLE);
   assign wr_flag_clr = wr_pend_q && (wr_addr_q == `PMT_OFF_FLAG_CLR);

   // **************************************************
   // Timer state
   // **************************************************
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic [7:0] period_q;
   logic [7:0] period_d;
   pmt_ctl_t ctl_q;
   pmt_ctl_t ctl_d;
   logic flag_q;
   logic flag_d;
   logic enable_q;
   logic enable_d;
   logic scaler_clear;
   logic tick;
   logic match;
   logic post_event;
   pmt_out_t out_q;
   pmt_out_t out_d;

   assign scaler_clear = wr_count || wr_control;

   pmt_prescaler #(
      .WIDTH(4)
   ) u_pre (
      .clk(clk),
      .rst_n(rst_n),
      .run(ctl_q.timer_run),
      .clear(scaler_clear),
      .select(ctl_q.clock_prescale_select),
      .tick(tick)
   );

   // Compare runs each timer tick; a stopped timer produces no match.
   assign match = tick && (count_q == period_q);

   pmt_postscaler #(
      .WIDTH(4)
   ) u_post (
      .clk(clk),
      .rst_n(rst_n),
      .clear(scaler_clear),
      .match(match),
      .select(ctl_q.output_postscale_select),
      .event_out(post_event)
   );

   always_comb begin
      count_d = count_q;
      // The matching tick loads zero, so one cycle spans the period value plus one ticks.
      if (wr_count) begin
         count_d = hwdata[7:0];
      end else if (match) begin
         count_d = 8'h00;
      end else if (tick) begin
         count_d = count_q + 8'h01;
      end
      // A control write leaves the count alone.
      period_d = wr_period ? hwdata[7:0] : period_q;
      ctl_d = wr_control ? pmt_ctl_t'(hwdata[6:0]) : ctl_q;
      enable_d = wr_enable ? hwdata[`PMT_MATCH_FLAG_BIT] : enable_q;
      // The setting event wins over a clear in the same cycle.
      flag_d = flag_q;
      if (wr_flag_clr && hwdata[`PMT_MATCH_FLAG_BIT]) begin
         flag_d = 1'b0;
      end
      if (post_event) begin
         flag_d = 1'b1;
      end
      out_d.match_pulse = match;
      out_d.time_base = match;
      out_d.shift_clock = match;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_q <= `PMT_COUNT_RST;
         period_q <= `PMT_PERIOD_RST;
         ctl_q <= pmt_ctl_t'(`PMT_CONTROL_RST);
         flag_q <= 1'b0;
         enable_q <= 1'b0;
         out_q <= '0;
      end else begin
         count_q <= count_d;
         period_q <= period_d;
         ctl_q <= ctl_d;
         flag_q <= flag_d;
         enable_q <= enable_d;
         out_q <= out_d;
      end
   end

   // **************************************************
   // Read path and outputs
   // **************************************************
   logic irq_q;
   logic irq_d;

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (addr_phase && !hwrite) begin
         case (haddr)
            `PMT_OFF_COUNT: rdata_d = {24'h000000, count_d};
            `PMT_OFF_PERIOD: rdata_d = {24'h000000, period_d};
            `PMT_OFF_CONTROL: rdata_d = {25'h0, ctl_d};
            `PMT_OFF_FLAGS: rdata_d = {30'h0, flag_d, 1'b0};
            `PMT_OFF_ENABLE: rdata_d = {30'h0, enable_d, 1'b0};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
      irq_d = flag_d && enable_d;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
         irq_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   assign hrdata = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = irq_q;
   assign pwm_time_base = out_q.time_base;
   assign spi_shift_clock = out_q.shift_clock;

   // **************************************************
   // Checks
   // **************************************************
   // Helper counters: cycles since the last tick, and matches since the last flag event.
   logic [4:0] gap_q;
   logic [4:0] gap_d;
   logic [4:0] seen_q;
   logic [4:0] seen_d;

   always_comb begin
      gap_d = gap_q;
      if (scaler_clear || tick) begin
         gap_d = 5'h00;
      end else if (ctl_q.timer_run && gap_q != 5'h1f) begin
         gap_d = gap_q + 5'h01;
      end
      seen_d = seen_q;
      if (scaler_clear || post_event) begin
         seen_d = 5'h00;
      end else if (match) begin
         seen_d = seen_q + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gap_q <= 5'h00;
         seen_q <= 5'h00;
      end else begin
         gap_q <= gap_d;
         seen_q <= seen_d;
      end
   end

   a_reset_values: assert property (@(posedge clk) $rose(rst_n) |->
      count_q == 8'h00 && period_q == 8'hff && ctl_q == 7'h00)
      else $error("reset values wrong");
   a_match_restart: assert property (@(posedge clk) disable iff (!rst_n)
      match && !wr_count |=> count_q == 8'h00)
      else $error("count not zeroed after match");
   a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
      tick && !match && !wr_count |=> count_q == $past(count_q) + 8'h01)
      else $error("count did not step");
   a_hold_stopped: assert property (@(posedge clk) disable iff (!rst_n)
      !ctl_q.timer_run && !wr_count |=> count_q == $past(count_q))
      else $error("stopped count moved");
   a_ctl_keeps: assert property (@(posedge clk) disable iff (!rst_n)
      wr_control && !tick |=> count_q == $past(count_q))
      else $error("control write changed count");
   a_match_eq: assert property (@(posedge clk) disable iff (!rst_n)
      match |-> count_q == period_q && ctl_q.timer_run)
      else $error("match without equality");
   a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      flag_q && !wr_flag_clr |=> flag_q)
      else $error("flag dropped");
   a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 irq == ($past(flag_d) && $past(enable_d)))
      else $error("irq not gated");
   a_time_base: assert property (@(posedge clk) disable iff (!rst_n)
      match |=> pwm_time_base && spi_shift_clock)
      else $error("time base missing");
   a_bit7_zero: assert property (@(posedge clk) disable iff (!rst_n)
      $past(addr_phase && !hwrite && haddr == `PMT_OFF_CONTROL) |-> !hrdata[7])
      else $error("bit seven read one");
   a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
      post_event |=> flag_q)
      else $error("flag not set");
   a_div4: assert property (@(posedge clk) disable iff (!rst_n)
      tick && ctl_q.clock_prescale_select == 2'h1 && !scaler_clear |=> !tick [*3])
      else $error("divide by four broken");

   // Divider spacing: every scaler clear restarts the gap, so a tick lands on a fixed gap.
   a_div1_gap: assert property (@(posedge clk) disable iff (!rst_n)
      tick && ctl_q.clock_prescale_select == 2'h0 |-> gap_q == 5'h00)
      else $error("divide by one spacing wrong");
   a_div4_gap: assert property (@(posedge clk) disable iff (!rst_n)
      tick && ctl_q.clock_prescale_select == 2'h1 |-> gap_q == 5'h03)
      else $error("divide by four spacing wrong");
   a_div16_gap: assert property (@(posedge clk) disable iff (!rst_n)
      tick && ctl_q.clock_prescale_select[1] |-> gap_q == 5'h0f)
      else $error("divide by sixteen spacing wrong");
   a_tick_due: assert property (@(posedge clk) disable iff (!rst_n)
      ctl_q.timer_run && ctl_q.clock_prescale_select == 2'h0 && !scaler_clear |-> tick)
      else $error("undivided tick missing");
   a_no_tick_off: assert property (@(posedge clk) disable iff (!rst_n)
      !ctl_q.timer_run |-> !tick)
      else $error("tick while stopped");
   a_no_match_stopped: assert property (@(posedge clk) disable iff (!rst_n)
      !ctl_q.timer_run |-> !match)
      else $error("match while stopped");
   a_count_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_count |=> count_q == $past(hwdata[7:0]))
      else $error("count write lost");
   a_period_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_period |=> period_q == $past(hwdata[7:0]))
      else $error("period write lost");
   a_ctl_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_control |=> ctl_q == $past(hwdata[6:0]))
      else $error("control write lost");
   a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_enable |=> enable_q == $past(hwdata[`PMT_MATCH_FLAG_BIT]))
      else $error("enable write lost");
   a_scaler_cleared: assert property (@(posedge clk) disable iff (!rst_n)
      scaler_clear |=> u_pre.pre_q == 4'h0 && u_post.post_q == 4'h0)
      else $error("scalers not cleared");

   // Postscale and interrupt side.
   a_post_count: assert property (@(posedge clk) disable iff (!rst_n)
      match |-> post_event == (seen_q == {1'b0, ctl_q.output_postscale_select}))
      else $error("postscale count wrong");
   a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
      wr_flag_clr && hwdata[`PMT_MATCH_FLAG_BIT] && !post_event |=> !flag_q)
      else $error("flag not cleared");
   a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
      !enable_q && !wr_enable |=> !irq)
      else $error("masked interrupt raised");
   a_pulse_single: assert property (@(posedge clk) disable iff (!rst_n)
      pwm_time_base && ctl_q.clock_prescale_select != 2'h0 |=> !pwm_time_base)
      else $error("match pulse too long");
   a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      !match |=> !pwm_time_base && !spi_shift_clock)
      else $error("pulse without match");
   a_read_zero_hi: assert property (@(posedge clk) disable iff (!rst_n)
      $past(addr_phase && !hwrite) |-> hrdata[31:8] == 24'h000000)
      else $error("upper read bits set");

   c_match: cover property (@(posedge clk) match);
   c_flag: cover property (@(posedge clk) post_event);
   c_irq: cover property (@(posedge clk) $rose(irq));
   c_div4: cover property (@(posedge clk) tick && ctl_q.clock_prescale_select == 2'h1);
   c_div16: cover property (@(posedge clk) tick && ctl_q.clock_prescale_select == 2'h2);

endmodule : pmt_timer

/* File: pmt_timer_tb_top.sv */
// Self-checking testbench of the period match timer.
`timescale 1ns/1ns
`include "pmt_consts.svh"

module pmt_timer_tb_top;
   import pmt_pkg::*;

   logic clk;
   logic rst_n;
   logic hsel;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   logic irq;
   logic pwm_time_base;
   logic spi_shift_clock;
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [31:0] xs = 32'h4ce2;

   pmt_timer i_pmt_timer (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .irq(irq), .pwm_time_base(pwm_time_base), .spi_shift_clock(spi_shift_clock));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ********************
   // Helpers
   // ********************
   function automatic logic [31:0] xorshift();
      xs = xs ^ (xs << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
      return xs;
   endfunction : xorshift

   task automatic results();
      if (num_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One clock; the serial shift clock must mirror the PWM time base.
   task automatic step();
      @(posedge clk);
      if (pwm_time_base !== 1'b0 || spi_shift_clock !== 1'b0) begin
         chk(32'(spi_shift_clock), 32'(pwm_time_base));
      end
   endtask : step

   // A single word transfer; hready is the slave's own hreadyout.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk(32'(hresp), 32'h0);
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, rd);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      chk(rd, exp);
   endtask : rd_chk

   task automatic wait_pulse(output int t);
      int k;
      for (k = 0; k < 5000 && pwm_time_base !== 1'b1; k++) begin
         step();
      end
      t = cyc;
      step();
   endtask : wait_pulse

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         num_errors++;
         results();
      end
   end

   // ********************
   // Main sequence
   // ********************
   initial begin
      int p, n, dv, pulses, t0, t1, k;
      logic [31:0] rd, c1;
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      chk(32'(irq), 32'h0);
      rd_chk(`PMT_OFF_COUNT, 32'h00);
      rd_chk(`PMT_OFF_PERIOD, 32'hff);
      rd_chk(`PMT_OFF_CONTROL, 32'h00);
      rd_chk(`PMT_OFF_FLAGS, 32'h00);
      rd_chk(12'h020, 32'h00);
      wr(`PMT_OFF_CONTROL, 32'hfb);
      rd_chk(`PMT_OFF_CONTROL, 32'h7b);
      wr(`PMT_OFF_COUNT, 32'h5a);
      rd_chk(`PMT_OFF_COUNT, 32'h5a);
      wr(`PMT_OFF_CONTROL, 32'h00);
      rd_chk(`PMT_OFF_COUNT, 32'h5a);
      for (int ps = 0; ps < 4; ps++) begin
         p = 2 + int'(xorshift() % 8);
         n = int'(xorshift() % 16);
         dv = (ps == 0) ? 1 : ((ps == 1) ? 4 : 16);
         wr(`PMT_OFF_PERIOD, 32'(p));
         rd_chk(`PMT_OFF_PERIOD, 32'(p));
         wr(`PMT_OFF_COUNT, 32'h0);
         wr(`PMT_OFF_FLAG_CLR, 32'h2);
         wr(`PMT_OFF_ENABLE, 32'h2);
         wr(`PMT_OFF_CONTROL, 32'((n << 3) | 4 | ps));
         pulses = 0;
         for (k = 0; k < 20000 && irq !== 1'b1; k++) begin
            step();
            if (pwm_time_base === 1'b1) pulses++;
         end
         chk(32'(pulses), 32'(n + 1));
         wait_pulse(t0);
         wait_pulse(t1);
         chk(32'(t1 - t0), 32'((p + 1) * dv));
         bus(1'b0, `PMT_OFF_COUNT, 32'h0, rd);
         chk(32'(rd[7:0] <= 8'(p)), 32'h1);
         rd_chk(`PMT_OFF_FLAGS, 32'h2);
         wr(`PMT_OFF_ENABLE, 32'h0);
         step();
         step();
         chk(32'(irq), 32'h0);
         wr(`PMT_OFF_CONTROL, 32'((n << 3) | ps));
         bus(1'b0, `PMT_OFF_COUNT, 32'h0, c1);
         pulses = 0;
         repeat (40) begin
            step();
            if (pwm_time_base === 1'b1) pulses++;
         end
         chk(32'(pulses), 32'h0);
         rd_chk(`PMT_OFF_COUNT, c1);
         wr(`PMT_OFF_FLAG_CLR, 32'h2);
         rd_chk(`PMT_OFF_FLAGS, 32'h0);
      end
      results();
   end

endmodule : pmt_timer_tb_top
